// ===== include/stat_reg_pkg.sv
package stat_reg_pkg;

  // Status byte field positions
  localparam int unsigned BIT_SWPE    = 7;
  localparam int unsigned BIT_QUAD    = 6;
  localparam int unsigned BIT_LAT_HI  = 5;
  localparam int unsigned BIT_LAT_LO  = 4;
  localparam int unsigned BIT_BP_HI   = 3;
  localparam int unsigned BIT_BP_LO   = 2;
  localparam int unsigned BIT_WEL     = 1;
  localparam int unsigned BIT_ZERO    = 0;

  // Reset values of the volatile bits and the constant bit
  localparam logic QUAD_RESET = 1'h0;
  localparam logic WEL_RESET  = 1'h0;
  localparam logic ZERO_VALUE = 1'h0;

  // Default contents of the nonvolatile cells on a blank part
  localparam logic       SWPE_BLANK = 1'h0;
  localparam logic [1:0] LAT_BLANK  = 2'h0;
  localparam logic [1:0] BP_BLANK   = 2'h0;

  // Decoded command strobes from the serial front end
  typedef struct packed {
    logic write_status;
    logic set_latch;
    logic clear_latch;
    logic enter_quad;
    logic enter_dual;
    logic exit_wide;
    logic wake_powerdown;
    logic wake_hibernate;
    logic mem_write_done;
  } cmd_strobe_t;

  // Complete state of the status register bank
  typedef struct packed {
    logic       swpe;
    logic       quad;
    logic [1:0] latency;
    logic [1:0] protect;
    logic       write_enable_latch;
  } stat_state_t;

endpackage : stat_reg_pkg

// ===== logic/stat_reg.sv
`timescale 1ns/1ns

// Overview of operation
// - Bit 7 write-protect enable, nonvolatile, gates status writes (not ARRAY_WRITABLE)
// - Write-status writes it; read-status returns it
// - Bit 6 quad flag: volatile, enter-quad sets
// - Write-status data never touches quad flag
// - Quad flag mirrored identically to second register
// - Bits 5:4 latency select, nonvolatile, read/write
// - Bits 3:2 block protect select, nonvolatile, read/write
// - Bit 1 latch set by set-write-latch command
// - Clear-write-latch command clears the latch
// - Latch readable, write-status cannot change it
// - Latch clears at power-on, wake from sleep
// - Latch stays set after any write command
// - Bit 0 always reads zero
module stat_reg
  import stat_reg_pkg::*;
(
  input  wire logic                      MCLK,
  input  wire logic                      NRST,
  input  wire stat_reg_pkg::cmd_strobe_t CMD,
  input  wire logic [7:0]                WDATA,
  input  wire logic                      WP_PIN_N,
  input  wire logic                      NV_VALID,
  input  wire logic                      NV_SWPE,
  input  wire logic [1:0]                NV_LATENCY,
  input  wire logic [1:0]                NV_PROTECT,
  output logic [7:0]                     STATUS1,
  output logic                           STATUS2_QUAD,
  output logic                           QUAD_MODE,
  output logic [1:0]                     LATENCY_SEL,
  output logic [1:0]                     PROTECT_SEL,
  output logic                           ARRAY_WRITABLE,
  output logic                           STATUS_WR_DONE,
  output logic                           STATUS_WR_REFUSED
);
  import stat_reg_pkg::*;

  typedef struct packed {
    stat_state_t st;
    logic        wp_meta;
    logic        wp_sync;
    logic        nv_meta;
    logic        nv_sync;
    logic        nv_loaded;
    logic        wr_done;
    logic        wr_refused;
  } core_t;

  core_t core_reg;
  core_t core_next;
  logic  status_locked;
  logic  wr_allowed;

  // Locked when the enable bit is set and the pin is held low
  assign status_locked = core_reg.st.swpe & ~core_reg.wp_sync;
  assign wr_allowed    = core_reg.st.write_enable_latch & ~status_locked;

  always_comb
  begin
    core_next            = core_reg;
    core_next.wp_meta    = WP_PIN_N;
    core_next.wp_sync    = core_reg.wp_meta;
    core_next.nv_meta    = NV_VALID;
    core_next.nv_sync    = core_reg.nv_meta;
    core_next.wr_done    = 1'h0;
    core_next.wr_refused = 1'h0;
    // Nonvolatile cells are copied in once after power-on recall
    if (core_reg.nv_sync && !core_reg.nv_loaded)
    begin
      core_next.nv_loaded  = 1'h1;
      core_next.st.swpe    = NV_SWPE;
      core_next.st.latency = NV_LATENCY;
      core_next.st.protect = NV_PROTECT;
      // A write that lands on the recall cycle is lost, so report it
      if (CMD.write_status)
      begin
        core_next.wr_refused = 1'h1;
      end
    end
    else if (CMD.write_status)
    begin
      if (wr_allowed)
      begin
        // Quad flag, latch and bit 0 are not taken from the byte
        core_next.st.swpe    = WDATA[BIT_SWPE];
        core_next.st.latency = WDATA[BIT_LAT_HI:BIT_LAT_LO];
        core_next.st.protect = WDATA[BIT_BP_HI:BIT_BP_LO];
        core_next.wr_done    = 1'h1;
      end
      else
      begin
        core_next.wr_refused = 1'h1;
      end
    end
    // Mode switches; exit and dual clear, quad sets
    if (CMD.enter_quad)
    begin
      core_next.st.quad = 1'h1;
    end
    else if (CMD.exit_wide || CMD.enter_dual)
    begin
      core_next.st.quad = QUAD_RESET;
    end
    // Clearing events outrank a same-cycle set so a wake never leaves it on
    if (CMD.clear_latch || CMD.wake_powerdown || CMD.wake_hibernate)
    begin
      core_next.st.write_enable_latch = WEL_RESET;
    end
    else if (CMD.set_latch)
    begin
      core_next.st.write_enable_latch = 1'h1;
    end
    // write_status and mem_write_done deliberately leave wel alone
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      core_reg            <= '0;
      core_reg.st.swpe    <= SWPE_BLANK;
      core_reg.st.quad    <= QUAD_RESET;
      core_reg.st.latency <= LAT_BLANK;
      core_reg.st.protect <= BP_BLANK;
      core_reg.st.write_enable_latch     <= WEL_RESET;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  always_comb
  begin
    STATUS1           = 8'h00;
    STATUS1[BIT_SWPE] = core_reg.st.swpe;
    STATUS1[BIT_QUAD] = core_reg.st.quad;
    STATUS1[BIT_LAT_HI:BIT_LAT_LO] = core_reg.st.latency;
    STATUS1[BIT_BP_HI:BIT_BP_LO]   = core_reg.st.protect;
    STATUS1[BIT_WEL]  = core_reg.st.write_enable_latch;
    STATUS1[BIT_ZERO] = ZERO_VALUE;
  end

  assign STATUS2_QUAD      = core_reg.st.quad;
  assign QUAD_MODE         = core_reg.st.quad;
  assign LATENCY_SEL       = core_reg.st.latency;
  assign PROTECT_SEL       = core_reg.st.protect;
  assign ARRAY_WRITABLE    = core_reg.st.write_enable_latch;
  assign STATUS_WR_DONE    = core_reg.wr_done;
  assign STATUS_WR_REFUSED = core_reg.wr_refused;

endmodule : stat_reg

// ===== tb/stat_host.sv
`timescale 1ns/1ns
module stat_host
  import stat_reg_pkg::*;
(
  input  wire logic                 MCLK,
  output stat_reg_pkg::cmd_strobe_t CMD,
  output logic [7:0]                WDATA
);
  initial
  begin
    CMD = '0;
    WDATA = 8'h00;
  end
  task send(input int f, input logic [7:0] d);
    @(negedge MCLK);
    CMD = cmd_strobe_t'(9'h001 << f);
    WDATA = d;
    @(negedge MCLK);
    CMD = '0;
    WDATA = ~d; // Stale byte inverted so it cannot pass for valid data
  endtask : send
endmodule : stat_host

// ===== tb/stat_reg_assertions.sv
`timescale 1ns/1ns
module stat_chk
  import stat_reg_pkg::*;
(
  input wire logic                      MCLK,
  input wire logic                      NRST,
  input wire stat_reg_pkg::cmd_strobe_t CMD,
  input wire logic [7:0]                WDATA,
  input wire logic [7:0]                STATUS1,
  input wire logic                      STATUS2_QUAD,
  input wire logic                      STATUS_WR_DONE,
  input wire logic                      STATUS_WR_REFUSED
);
  logic clr;
  assign clr = CMD.clear_latch | CMD.wake_powerdown | CMD.wake_hibernate;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  sequence s_ok; CMD.write_status ##1 STATUS_WR_DONE; endsequence
  property p_mir; STATUS2_QUAD == STATUS1[6]; endproperty
  a_mir: assert property (p_mir) else $error("quad copy");
  property p_set; CMD.set_latch && !clr |=> STATUS1[1]; endproperty
  a_set: assert property (p_set) else $error("latch set");
  property p_clr; clr |=> !STATUS1[1]; endproperty
  a_clr: assert property (p_clr) else $error("latch clear");
  property p_eq; CMD.enter_quad |=> STATUS1[6]; endproperty
  a_eq: assert property (p_eq) else $error("quad set");
  property p_ex;
    (CMD.exit_wide || CMD.enter_dual) && !CMD.enter_quad |=> !STATUS1[6];
  endproperty
  a_ex: assert property (p_ex) else $error("quad clear");
  property p_qst;
    !(CMD.enter_quad || CMD.exit_wide || CMD.enter_dual)
      |=> $stable(STATUS1[6]);
  endproperty
  a_qst: assert property (p_qst) else $error("quad moved");
  property p_wst; !(clr || CMD.set_latch) |=> $stable(STATUS1[1]); endproperty
  a_wst: assert property (p_wst) else $error("latch moved");
  property p_ans;
    CMD.write_status |=> STATUS_WR_DONE != STATUS_WR_REFUSED;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_val; s_ok |-> (STATUS1 & 8'hBC) == ($past(WDATA) & 8'hBC);
  endproperty
  a_val: assert property (p_val) else $error("stored byte");
endmodule : stat_chk
bind stat_reg stat_chk u_chk (.MCLK(MCLK), .NRST(NRST), .CMD(CMD),
  .WDATA(WDATA), .STATUS1(STATUS1), .STATUS2_QUAD(STATUS2_QUAD),
  .STATUS_WR_DONE(STATUS_WR_DONE), .STATUS_WR_REFUSED(STATUS_WR_REFUSED));

// ===== tb/stat_reg_tb_top.sv
`timescale 1ns/1ns
module stat_reg_tb_top;
  import stat_reg_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, s2q, qm, aw, wp_n = 1'b0, wdn, wrf;
  cmd_strobe_t cmd;
  logic [7:0] wdata, status1;
  int mismatches = 0, comparisons = 0;
  // Strobe index, write byte, expected status byte
  localparam logic [19:0] STEPS [16] = '{20'h8FF24, 20'h70026, 20'h84302,
    20'h8BCBE, 20'h800BE, 20'h500FE, 20'h300BE, 20'h500FE, 20'h400BE,
    20'h600BC, 20'h700BE, 20'h200BC, 20'h700BE, 20'h100BC, 20'h700BE,
    20'h000BE};
  always #25 mclk = ~mclk;
  stat_host host (.MCLK(mclk), .CMD(cmd), .WDATA(wdata));
  stat_reg uut (.MCLK(mclk), .NRST(nrst), .CMD(cmd), .WDATA(wdata),
    .WP_PIN_N(wp_n), .NV_VALID(1'b1), .NV_SWPE(1'b0), .NV_LATENCY(2'h2),
    .NV_PROTECT(2'h1), .STATUS1(status1), .STATUS2_QUAD(s2q),
    .QUAD_MODE(qm), .LATENCY_SEL(), .PROTECT_SEL(), .ARRAY_WRITABLE(aw),
    .STATUS_WR_DONE(wdn), .STATUS_WR_REFUSED(wrf));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task finish_test;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    #(50 * 2000);
    mismatches++;
    finish_test;
  end
  initial
  begin
    logic [7:0] e;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (6) @(negedge mclk);
    chk("recall", status1, 8'h24);
    foreach (STEPS[i])
    begin
      e = STEPS[i][7:0];
      host.send(int'(STEPS[i][19:16]), STEPS[i][15:8]);
      chk("status", status1, e);
      chk("flags", {5'h00, s2q, qm, aw}, {5'h00, e[6], e[6], e[1]});
    end
    host.send(8, 8'h00);
    chk("locked", {6'h00, wdn, wrf}, 8'h01);
    wp_n = 1'b1;
    repeat (3) @(negedge mclk);
    host.send(8, 8'h00);
    chk("unlocked", {6'h00, wdn, wrf}, 8'h02);
    chk("status", status1, 8'h02);
    finish_test;
  end
endmodule : stat_reg_tb_top
